// File: design/olcl_limiter.sv
// Inverse-time overload current limiter with Avalon-MM register slave
// How it works
// - Integrate current excess above the overload target each tick.
// - Allow overload for the delay, then reduce limit toward target.
// - Downward ramp rate follows the ramp-down duration register.
// - When overload ends, ramp the allowed limit back up.
// - Recovery target is min of frame normal level, twice continuous current and ceiling.
// - Below 2.5 Hz electrical, delay is a quarter of configured.
// - Target in 0.01 percent of stage current, 50.00 to 105.00.
// - Delay threshold is built from the normal allowed level.
// - Reported allowed level never exceeds the motor current ceiling.
// - While limiting, level equals target clamped by 105 percent or continuous.
// - Fan-load mode normal level is 110 percent.
// - Smallest frames use 200 percent and delay capped at 4 s.
// - Mobile frames use 175 percent.
// - Other frames use 150 percent.
// - Limiting flag set while reduction in effect, false after reset.
// - Warning flag shows overload reduction acting, false after reset.
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`include "olcl_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module olcl_limiter #(
  parameter logic [15:0] TICK_CYCLES = 16'(`OLCL_TICK_CYCLES)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [15:0] i_motor_current,
  input wire logic [15:0] i_elec_speed,
  output logic [15:0] o_allowed_current_level,
  output logic o_limiting_active_flag,
  output logic o_reduction_warning_flag
);

  // ****************************************
  // Register file
  // ****************************************
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [15:0] target_r, target_nxt;
  logic [15:0] delay_r, delay_nxt;
  logic [15:0] down_r, down_nxt;
  logic [15:0] up_r, up_nxt;
  logic [15:0] perm_r, perm_nxt;
  logic [15:0] ceil_r, ceil_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] wval;

  // Clamps a written value into its legal range
  function automatic logic [15:0] clampv(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  // One wait state per access keeps read data registered
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign o_avs_readdata = rdata_r;
  assign wval = i_avs_writedata[15:0];

  olcl_pkg::olcl_state_t st_r, st_nxt;
  logic [15:0] level_r, level_nxt;
  logic [31:0] integ_r, integ_nxt;
  logic limit_r, limit_nxt;
  logic warn_r, warn_nxt;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    target_nxt = target_r;
    delay_nxt = delay_r;
    down_nxt = down_r;
    up_nxt = up_r;
    perm_nxt = perm_r;
    ceil_nxt = ceil_r;
    ack_nxt = 1'b0;
    rdata_nxt = rdata_r;
    // Write lands at the edge where waitrequest is low, as the master sees it
    if (i_avs_write & ack_r & i_avs_byteenable[0] & i_avs_byteenable[1])
    begin
      case (i_avs_address)
        `OLCL_OFF_CTRL: ctrl_nxt = wval[2:0];
        `OLCL_OFF_TARGET: target_nxt = clampv(wval, `OLCL_TARGET_MIN, `OLCL_TARGET_MAX);
        `OLCL_OFF_DELAY: delay_nxt = clampv(wval, `OLCL_DELAY_MIN, `OLCL_DELAY_MAX);
        `OLCL_OFF_DOWN: down_nxt = clampv(wval, `OLCL_RAMP_MIN, `OLCL_RAMP_MAX);
        `OLCL_OFF_UP: up_nxt = clampv(wval, `OLCL_RAMP_MIN, `OLCL_RAMP_MAX);
        `OLCL_OFF_PERM: perm_nxt = wval;
        `OLCL_OFF_CEIL: ceil_nxt = wval;
        default: ;
      endcase
    end
    if ((i_avs_read | i_avs_write) & ~ack_r)
    begin
      ack_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (i_avs_read)
      begin
        case (i_avs_address)
          `OLCL_OFF_CTRL: rdata_nxt = {29'h0, ctrl_r};
          `OLCL_OFF_TARGET: rdata_nxt = {16'h0, target_r};
          `OLCL_OFF_DELAY: rdata_nxt = {16'h0, delay_r};
          `OLCL_OFF_DOWN: rdata_nxt = {16'h0, down_r};
          `OLCL_OFF_UP: rdata_nxt = {16'h0, up_r};
          `OLCL_OFF_PERM: rdata_nxt = {16'h0, perm_r};
          `OLCL_OFF_CEIL: rdata_nxt = {16'h0, ceil_r};
          `OLCL_OFF_STATUS: rdata_nxt = {30'h0, warn_r, limit_r};
          `OLCL_OFF_LEVEL: rdata_nxt = {16'h0, level_r};
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ctrl_r <= 3'h0;
      target_r <= `OLCL_TARGET_RST;
      delay_r <= `OLCL_DELAY_RST;
      down_r <= `OLCL_RAMP_RST;
      up_r <= `OLCL_RAMP_RST;
      perm_r <= `OLCL_PERM_RST;
      ceil_r <= `OLCL_CEIL_RST;
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      ctrl_r <= ctrl_nxt;
      target_r <= target_nxt;
      delay_r <= delay_nxt;
      down_r <= down_nxt;
      up_r <= up_nxt;
      perm_r <= perm_nxt;
      ceil_r <= ceil_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Levels and delay threshold
  // ****************************************
  logic [15:0] frame_norm, norm_lvl, tgt_eff, dly_eff, span_ov;
  logic [16:0] perm_x2;
  logic [31:0] base_thr, thr;
  logic slow;

  always_comb
  begin
    if (ctrl_r[`OLCL_CTRL_FAN_BIT])
      frame_norm = `OLCL_NORM_FAN;
    else
    begin
      case (olcl_pkg::olcl_frame_t'(ctrl_r[`OLCL_CTRL_FRAME_MSB:`OLCL_CTRL_FRAME_LSB]))
        olcl_pkg::OLCL_FRAME_SMALL: frame_norm = `OLCL_NORM_SMALL;
        olcl_pkg::OLCL_FRAME_MOBILE: frame_norm = `OLCL_NORM_MOBILE;
        default: frame_norm = `OLCL_NORM_OTHER;
      endcase
    end
    perm_x2 = {perm_r, 1'b0};
    // recovery level: frame level bounded by twice continuous current and ceiling
    norm_lvl = min16(frame_norm, min16(ceil_r, perm_x2[16] ? 16'hFFFF : perm_x2[15:0]));
    // target clamped by 105 percent and continuous current
    tgt_eff = min16(min16(target_r, `OLCL_LIMIT_CAP), min16(perm_r, ceil_r));
    if (~ctrl_r[`OLCL_CTRL_FAN_BIT] && ctrl_r[1:0] == 2'h1)
      dly_eff = min16(delay_r, `OLCL_DELAY_SMALL_CAP);
    else
      dly_eff = delay_r;
    // threshold from overload at the normal level over the delay
    span_ov = (norm_lvl > tgt_eff) ? (norm_lvl - tgt_eff) : 16'h0001;
    base_thr = 32'(span_ov) * 32'(dly_eff) * 32'(`OLCL_TICKS_PER_UNIT);
    slow = i_elec_speed < `OLCL_SLOW_SPEED;
    thr = slow ? (base_thr >> 2) : base_thr;
  end

  // ****************************************
  // Tick and ramp state machine
  // ****************************************
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  logic [16:0] dur_ticks;
  logic [15:0] span, step;
  logic [32:0] integ_sum;

  assign tick = tick_cnt_r == TICK_CYCLES - 16'h0001;

  always_comb
  begin
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    st_nxt = st_r;
    level_nxt = level_r;
    integ_nxt = integ_r;
    integ_sum = 33'h0;
    // linear step sized to cover the span in the set duration
    dur_ticks = 17'((st_r == olcl_pkg::OLCL_UP) ? up_r : down_r) * `OLCL_TICKS_PER_UNIT;
    span = (norm_lvl > tgt_eff) ? (norm_lvl - tgt_eff) : 16'h0000;
    step = 16'(17'(span) / dur_ticks);
    if (step == 16'h0000)
      step = 16'h0001;
    if (tick)
    begin
      // integrate excess, leak deficit, saturate both ways
      if (i_motor_current > tgt_eff)
      begin
        integ_sum = 33'(integ_r) + 33'(i_motor_current - tgt_eff);
        integ_nxt = integ_sum[32] ? 32'hFFFF_FFFF : integ_sum[31:0];
      end
      else
        integ_nxt = (integ_r > 32'(tgt_eff - i_motor_current)) ?
                    integ_r - 32'(tgt_eff - i_motor_current) : 32'h0;
    end
    case (st_r)
      olcl_pkg::OLCL_NORMAL:
      begin
        level_nxt = norm_lvl;
        if (tick && integ_r >= thr)
          st_nxt = olcl_pkg::OLCL_DOWN;
      end
      olcl_pkg::OLCL_DOWN:
      begin
        if (tick)
        begin
          if (level_r > tgt_eff + step)
            level_nxt = level_r - step;
          else
          begin
            level_nxt = tgt_eff;
            st_nxt = olcl_pkg::OLCL_LIMIT;
          end
          if (i_motor_current < tgt_eff)
          begin
            st_nxt = olcl_pkg::OLCL_UP;
            integ_nxt = 32'h0;
          end
        end
      end
      olcl_pkg::OLCL_LIMIT:
      begin
        level_nxt = tgt_eff;
        if (tick && i_motor_current < tgt_eff)
        begin
          st_nxt = olcl_pkg::OLCL_UP;
          integ_nxt = 32'h0;
        end
      end
      olcl_pkg::OLCL_UP:
      begin
        if (tick)
        begin
          if (integ_r >= thr)
            st_nxt = olcl_pkg::OLCL_DOWN;
          // ramp back up to the normal level
          else if (level_r + step < norm_lvl)
            level_nxt = level_r + step;
          else
          begin
            level_nxt = norm_lvl;
            st_nxt = olcl_pkg::OLCL_NORMAL;
          end
        end
      end
      default:
      begin
        st_nxt = olcl_pkg::OLCL_NORMAL;
        level_nxt = norm_lvl;
      end
    endcase
    if (level_nxt > ceil_r)
      level_nxt = ceil_r;
    limit_nxt = st_nxt == olcl_pkg::OLCL_DOWN || st_nxt == olcl_pkg::OLCL_LIMIT;
    warn_nxt = integ_nxt >= thr;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      tick_cnt_r <= 16'h0000;
      st_r <= olcl_pkg::OLCL_NORMAL;
      level_r <= `OLCL_NORM_OTHER;
      integ_r <= 32'h0000_0000;
      limit_r <= 1'b0;
      warn_r <= 1'b0;
    end
    else if (i_ce)
    begin
      tick_cnt_r <= tick_cnt_nxt;
      st_r <= st_nxt;
      level_r <= level_nxt;
      integ_r <= integ_nxt;
      limit_r <= limit_nxt;
      warn_r <= warn_nxt;
    end
  end

  assign o_allowed_current_level = level_r;
  assign o_limiting_active_flag = limit_r;
  assign o_reduction_warning_flag = warn_r;

  // ****************************************
  // Checks
  // ****************************************
  a_integral_grows: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_ce && tick && st_r == olcl_pkg::OLCL_NORMAL && i_motor_current > tgt_eff &&
    integ_r < 32'h7FFF_0000 |=> integ_r > $past(integ_r))
    else $error("Overload integral did not grow");
  a_trip_delay: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_ce && tick && st_r == olcl_pkg::OLCL_NORMAL && integ_r >= thr
    |=> st_r == olcl_pkg::OLCL_DOWN && o_limiting_active_flag)
    else $error("Limiter did not start ramp down");
  a_down_step: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_ce && tick && st_r == olcl_pkg::OLCL_DOWN && level_r > tgt_eff + step &&
    level_r <= ceil_r |=> level_r == $past(level_r) - $past(step))
    else $error("Ramp down step wrong");
  a_up_on_end: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_ce && tick && st_r == olcl_pkg::OLCL_LIMIT && i_motor_current < tgt_eff
    |=> st_r == olcl_pkg::OLCL_UP && integ_r == 32'h0)
    else $error("Recovery did not start");
  a_slow_delay: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    slow |-> thr == (base_thr >> 2))
    else $error("Low speed delay not quartered");
  a_level_ceiling: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_allowed_current_level <= $past(ceil_r))
    else $error("Allowed level above ceiling");
  a_limit_level: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_ce && st_r == olcl_pkg::OLCL_LIMIT |=> o_allowed_current_level == $past(tgt_eff))
    else $error("Limiting level not target");
  a_normal_level: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_ce && st_r == olcl_pkg::OLCL_NORMAL
    |=> o_allowed_current_level == min16($past(norm_lvl), $past(ceil_r)))
    else $error("Normal level wrong");
  a_flags_reset: assert property (
    @(posedge i_ref_clk)
    $past(i_rst) |-> !o_limiting_active_flag && !o_reduction_warning_flag && integ_r == 32'h0)
    else $error("Flags not clear after reset");

endmodule

`default_nettype wire

// File: design/olcl_pkg.sv
// Types shared by the overload limiter
package olcl_pkg;

  typedef enum logic [3:0] {
    OLCL_NORMAL = 4'h1,
    OLCL_DOWN = 4'h2,
    OLCL_LIMIT = 4'h4,
    OLCL_UP = 4'h8
  } olcl_state_t;

  typedef enum logic [1:0] {
    OLCL_FRAME_OTHER = 2'h0,
    OLCL_FRAME_SMALL = 2'h1,
    OLCL_FRAME_MOBILE = 2'h2
  } olcl_frame_t;

endpackage

// File: design/olcl_regs.svh
// Register offsets, field positions, reset values and timing counts of the overload limiter
`ifndef OLCL_REGS_SVH
`define OLCL_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OLCL_OFF_CTRL 6'h00
`define OLCL_OFF_TARGET 6'h04
`define OLCL_OFF_DELAY 6'h08
`define OLCL_OFF_DOWN 6'h0C
`define OLCL_OFF_UP 6'h10
`define OLCL_OFF_PERM 6'h14
`define OLCL_OFF_CEIL 6'h18
`define OLCL_OFF_STATUS 6'h1C
`define OLCL_OFF_LEVEL 6'h20

// ****************************************
// Fields
// ****************************************
`define OLCL_CTRL_FRAME_LSB 0
`define OLCL_CTRL_FRAME_MSB 1
`define OLCL_CTRL_FAN_BIT 2
`define OLCL_STAT_LIMIT_BIT 0
`define OLCL_STAT_WARN_BIT 1

// ****************************************
// Levels in 0.01 percent, times in 0.1 s
// ****************************************
`define OLCL_TARGET_RST 16'h2904
`define OLCL_TARGET_MIN 16'h1388
`define OLCL_TARGET_MAX 16'h2904
`define OLCL_LIMIT_CAP 16'h2904
`define OLCL_NORM_FAN 16'h2AF8
`define OLCL_NORM_SMALL 16'h4E20
`define OLCL_NORM_MOBILE 16'h445C
`define OLCL_NORM_OTHER 16'h3A98
`define OLCL_PERM_RST 16'h2710
`define OLCL_CEIL_RST 16'h4E20
`define OLCL_DELAY_RST 16'h0028
`define OLCL_DELAY_MIN 16'h0005
`define OLCL_DELAY_MAX 16'h0258
`define OLCL_DELAY_SMALL_CAP 16'h0028
`define OLCL_RAMP_RST 16'h000A
`define OLCL_RAMP_MIN 16'h0005
`define OLCL_RAMP_MAX 16'h0064
`define OLCL_SLOW_SPEED 16'h0019

// ****************************************
// Timing: tick of 1 ms, clock of 100 ns
// ****************************************
`define OLCL_CLK_PERIOD_NS 100
`define OLCL_TICK_NS 1000000
`define OLCL_TICK_CYCLES (`OLCL_TICK_NS / `OLCL_CLK_PERIOD_NS)
`define OLCL_TICKS_PER_UNIT 17'h00064

`endif

// File: tb/olcl_motor_model.sv
// Motor current source model held under the allowed level
`timescale 1ns/1ns
`default_nettype none
module olcl_motor_model (
  input wire logic i_ref_clk,
  input wire logic [15:0] i_demand,
  input wire logic [15:0] i_speed,
  input wire logic [15:0] i_allowed,
  output logic [15:0] o_current,
  output logic [15:0] o_speed
);
  // Drive path cannot push more than the allowed level, one cycle lag
  always_ff @(posedge i_ref_clk)
  begin
    o_current <= (i_demand > i_allowed) ? i_allowed : i_demand;
    o_speed <= i_speed;
  end
endmodule
`default_nettype wire

// File: tb/test_olcl_limiter.sv
// Self-checking bench of the overload current limiter
`include "olcl_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module test_olcl_limiter;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [15:0] demand = 16'h0000;
  logic [15:0] spd = 16'h0000;
  logic [31:0] rdata;
  logic wait_rq;
  logic [15:0] cur;
  logic [15:0] mspd;
  logic [15:0] lvl;
  logic lim;
  logic warn;
  int miscompares = 0;
  int check_count = 0;

  // Short tick keeps half-second ramps and delays inside the run
  olcl_limiter #(.TICK_CYCLES(16'h000A)) i_dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
    .i_motor_current(cur), .i_elec_speed(mspd), .o_allowed_current_level(lvl),
    .o_limiting_active_flag(lim), .o_reduction_warning_flag(warn));
  olcl_motor_model i_motor (.i_ref_clk(clk), .i_demand(demand), .i_speed(spd),
    .i_allowed(lvl), .o_current(cur), .o_speed(mspd));

  initial
  begin
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task win(input string what, input int n, input int lo, input int hi);
    chk(what, 32'h1, {31'h0, (n >= lo && n <= hi)});
  endtask

  // Request held until a rising edge samples waitrequest low; data taken there
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wd <= d;
    be <= b;
    @(posedge clk);
    while (wait_rq !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    win("bus answer", n, 1, 19);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task rdchk(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(what, exp, q);
  endtask

  task wrr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, 4'hF, q);
  endtask

  task measure(input logic on_lvl, input logic [15:0] v, output int n);
    n = 0;
    @(negedge clk);
    while ((on_lvl ? (lvl !== v) : (lim !== 1'b1)) && n < 9000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    logic [15:0] rv [8];
    rv = '{16'h0000, 16'h2904, 16'h0028, 16'h000A, 16'h000A, 16'h2710, 16'h4E20, 16'h0000};
    chk("limiting", 32'h0, {31'h0, lim});
    chk("warning", 32'h0, {31'h0, warn});
    chk("level", 32'h3A98, {16'h0, lvl});
    for (int i = 0; i < 8; i++)
      rdchk("reset reg", 6'(i * 4), {16'h0000, rv[i]});
    rdchk("unmapped", 6'h3C, 32'h0);
    $display("test reset done");
  endtask

  task t_config();
    logic [31:0] q;
    wrr(`OLCL_OFF_TARGET, 16'h0FA0);
    rdchk("target low", `OLCL_OFF_TARGET, 32'h1388);
    bus(1'b1, `OLCL_OFF_TARGET, 32'h1F40, 4'hC, q);
    rdchk("target be", `OLCL_OFF_TARGET, 32'h1388);
    wrr(`OLCL_OFF_TARGET, 16'h2904);
    wrr(`OLCL_OFF_LEVEL, 16'h0000);
    rdchk("level ro", `OLCL_OFF_LEVEL, 32'h3A98);
    wrr(`OLCL_OFF_DELAY, 16'h0005);
    wrr(`OLCL_OFF_DOWN, 16'h0005);
    wrr(`OLCL_OFF_UP, 16'h0005);
    wrr(`OLCL_OFF_PERM, 16'h2AF8);
    $display("test config done");
  endtask

  task t_frames();
    logic [15:0] code [4];
    logic [15:0] lv [4];
    code = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};
    lv = '{16'h3A98, 16'h4E20, 16'h445C, 16'h2AF8};
    for (int i = 0; i < 4; i++)
    begin
      wrr(`OLCL_OFF_CTRL, code[i]);
      repeat (3) @(posedge clk);
      chk("frame level", {16'h0, lv[i]}, {16'h0, lvl});
    end
    wrr(`OLCL_OFF_CTRL, 16'h0001);
    wrr(`OLCL_OFF_CEIL, 16'h3E80);
    repeat (3) @(posedge clk);
    chk("ceiling clamp", 32'h3E80, {16'h0, lvl});
    wrr(`OLCL_OFF_CEIL, 16'h4E20);
    wrr(`OLCL_OFF_PERM, 16'h1F40);
    repeat (3) @(posedge clk);
    chk("twice perm", 32'h3E80, {16'h0, lvl});
    wrr(`OLCL_OFF_PERM, 16'h2AF8);
    wrr(`OLCL_OFF_CTRL, 16'h0000);
    $display("test frames done");
  endtask

  // Excess 4500 per tick against (15000-10500)*5*100, quartered at low speed
  task t_overload(input logic [15:0] s, input int ticks);
    int n;
    @(posedge clk);
    spd <= s;
    demand <= 16'h4E20;
    measure(1'b0, 16'h0000, n);
    win("onset", n, (ticks - 3) * 10, (ticks + 3) * 10);
    @(negedge clk);
    chk("warning on", 32'h1, {31'h0, warn});
    measure(1'b1, 16'h2904, n);
    win("down ramp", n, 4970, 5030);
    rdchk("status", `OLCL_OFF_STATUS, 32'h3);
    rdchk("level reg", `OLCL_OFF_LEVEL, 32'h2904);
    @(posedge clk);
    demand <= 16'h1388;
    repeat (40) @(posedge clk);
    chk("limiting off", 32'h0, {31'h0, lim});
    chk("warning off", 32'h0, {31'h0, warn});
    measure(1'b1, 16'h3A98, n);
    win("up ramp", n + 40, 4970, 5030);
    $display("test overload done, onset ticks %0d", ticks);
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_config();
    t_frames();
    t_overload(16'h0000, 125);
    t_overload(16'h0064, 500);
    give_verdict();
  end
endmodule
`default_nettype wire
